// ===== hw/ict_defines.svh
// Timing constants and per-class cycle costs of the instruction timing sequencer.
`ifndef ICT_DEFINES_SVH
`define ICT_DEFINES_SVH

// ==========================================
// Widths and bus cycle length
`define ICT_CLK_W 10
`define ICT_CNT_W 7
`define ICT_BUS_CLKS 10'h004
`define ICT_BUS_LAST 2'h3

// ==========================================
// Costs packed as {clocks[9:0], reads[6:0], writes[6:0]}
`define ICT_SHIFT_BW_BASE 10'h00A
`define ICT_SHIFT_L_BASE 10'h00C
`define ICT_SHIFT_RD 7'h02
`define ICT_C_SHIFT_MEM {10'h010, 7'h02, 7'h02}
`define ICT_C_BIT_DYN {10'h00C, 7'h02, 7'h00}
`define ICT_C_BIT_DYN_CLR {10'h00E, 7'h02, 7'h00}
`define ICT_C_BIT_DYN_TST {10'h00A, 7'h02, 7'h00}
`define ICT_C_BIT_STA {10'h014, 7'h04, 7'h00}
`define ICT_C_BIT_STA_CLR {10'h016, 7'h04, 7'h00}
`define ICT_C_BIT_STA_TST {10'h012, 7'h04, 7'h00}
`define ICT_C_BR_TAKEN {10'h012, 7'h04, 7'h00}
`define ICT_C_BR_NT_BYTE {10'h00C, 7'h02, 7'h00}
`define ICT_C_BR_NT_WORD {10'h014, 7'h04, 7'h00}
`define ICT_C_CHK_TRAP {10'h044, 7'h08, 7'h06}
`define ICT_C_CHK_PASS {10'h00E, 7'h02, 7'h00}
`define ICT_MULTI_REGISTER_MOVE_OP_LD_CLK 10'h018
`define ICT_MULTI_REGISTER_MOVE_OP_LD_RD 7'h06
`define ICT_MULTI_REGISTER_MOVE_OP_ST_CLK 10'h010
`define ICT_MULTI_REGISTER_MOVE_OP_ST_RD 7'h04
`define ICT_C_JUMP {10'h010, 7'h04, 7'h00}
`define ICT_C_CALL {10'h020, 7'h04, 7'h04}
`define ICT_C_LOAD_ADDR {10'h008, 7'h02, 7'h00}
`define ICT_C_PUSH_ADDR {10'h018, 7'h02, 7'h04}
`define ICT_C_XADD_REG_BW {10'h008, 7'h02, 7'h00}
`define ICT_C_XADD_REG_L {10'h00C, 7'h02, 7'h00}
`define ICT_C_XADD_MEM_B {10'h016, 7'h04, 7'h01}
`define ICT_C_XADD_MEM_W {10'h032, 7'h06, 7'h02}
`define ICT_C_XADD_MEM_L {10'h03A, 7'h0A, 7'h04}
`define ICT_C_EXC_BUS {10'h05E, 7'h08, 7'h0E}
`define ICT_C_EXC_TRAP {10'h03E, 7'h08, 7'h06}
`define ICT_C_EXC_INT {10'h048, 7'h09, 7'h06}
`define ICT_C_RESET {10'h040, 7'h0C, 7'h00}

// ==========================================
// Operand address costs, byte/word and long
`define ICT_C_EA_NONE {10'h000, 7'h00, 7'h00}
`define ICT_C_EA_IND_BW {10'h004, 7'h01, 7'h00}
`define ICT_C_EA_IND_L {10'h008, 7'h02, 7'h00}
`define ICT_C_EA_PRE_BW {10'h006, 7'h01, 7'h00}
`define ICT_C_EA_PRE_L {10'h00A, 7'h02, 7'h00}
`define ICT_C_EA_DISP_BW {10'h008, 7'h02, 7'h00}
`define ICT_C_EA_DISP_L {10'h00C, 7'h03, 7'h00}
`define ICT_C_EA_IDX_BW {10'h00A, 7'h02, 7'h00}
`define ICT_C_EA_IDX_L {10'h00E, 7'h03, 7'h00}
`define ICT_C_EA_ABSL_BW {10'h00C, 7'h03, 7'h00}
`define ICT_C_EA_ABSL_L {10'h010, 7'h04, 7'h00}

`endif

// ===== hw/ict_pkg.sv
// Types shared by the instruction timing sequencer.
`include "ict_defines.svh"

package ict_pkg;

  typedef enum logic [4:0] {
    CL_SHIFT_REG = 5'h00, CL_SHIFT_MEM = 5'h01, CL_BIT_REG = 5'h02, CL_BRANCH = 5'h03,
    CL_CHK = 5'h04, CL_MULTI_REGISTER_MOVE_OP_LD = 5'h05, CL_MULTI_REGISTER_MOVE_OP_ST = 5'h06, CL_JUMP = 5'h07,
    CL_CALL = 5'h08, CL_LOAD_ADDR = 5'h09, CL_PUSH_ADDR = 5'h0A, CL_XADD_REG = 5'h0B,
    CL_XADD_MEM = 5'h0C, CL_EXC_BUS = 5'h0D, CL_EXC_TRAP = 5'h0E, CL_EXC_INT = 5'h0F
  } ict_class_t;

  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} ict_size_t;

  typedef enum logic [1:0] {BIT_CHANGE = 2'h0, BIT_CLEAR = 2'h1, BIT_SET = 2'h2, BIT_TEST = 2'h3} ict_bitop_t;

  typedef enum logic [3:0] {
    EA_DREG = 4'h0, EA_AREG = 4'h1, EA_IND = 4'h2, EA_POSTINC = 4'h3, EA_PREDEC = 4'h4,
    EA_DISP = 4'h5, EA_INDEX = 4'h6, EA_ABSW = 4'h7, EA_ABSL = 4'h8, EA_PCDISP = 4'h9,
    EA_PCINDEX = 4'hA, EA_IMM = 4'hB
  } ict_ea_mode_t;

  typedef enum logic [1:0] {BK_READ = 2'h0, BK_WRITE = 2'h1, BK_IACK = 2'h2} ict_bus_kind_t;

  typedef enum logic [2:0] {
    ST_BOOT = 3'h0, ST_READY = 3'h1, ST_LOAD = 3'h2, ST_READ = 3'h3, ST_IDLE = 3'h4, ST_WRITE = 3'h5
  } ict_state_t;

  typedef struct packed {
    logic [`ICT_CLK_W-1:0] clks;
    logic [`ICT_CNT_W-1:0] reads;
    logic [`ICT_CNT_W-1:0] writes;
  } ict_cost_t;

  typedef struct packed {
    ict_class_t cls;
    ict_size_t size;
    ict_bitop_t bitop;
    ict_ea_mode_t ea_mode;
    logic [5:0] count;
    logic taken;
    logic disp_word;
    logic static_num;
  } ict_req_t;

  typedef struct packed {
    logic active;
    logic rd;
    logic wr;
    logic iack;
  } ict_bus_t;

endpackage

// ===== hw/ict_ea_cost.sv
// Registered lookup of operand address computation cost.
`timescale 1ns/1ps

module ict_ea_cost (
  input wire logic clk_in, // System clock.
  input wire logic rst_n_in, // Synchronised reset, active low.
  input wire logic load_in, // Capture a new lookup.
  input wire ict_pkg::ict_ea_mode_t mode_in, // Addressing mode.
  input wire logic long_in, // Long operand.
  output ict_pkg::ict_cost_t cost_out // Registered cost.
);
  import ict_pkg::*;

  ict_cost_t state;
  ict_cost_t next_state;

  // ==========================================
  // Lookup
  always_comb begin
    next_state = state;
    if (load_in) begin
      case (mode_in)
        EA_IND, EA_POSTINC: next_state = long_in ? `ICT_C_EA_IND_L : `ICT_C_EA_IND_BW;
        EA_PREDEC: next_state = long_in ? `ICT_C_EA_PRE_L : `ICT_C_EA_PRE_BW;
        EA_DISP, EA_ABSW, EA_PCDISP: next_state = long_in ? `ICT_C_EA_DISP_L : `ICT_C_EA_DISP_BW;
        EA_INDEX, EA_PCINDEX: next_state = long_in ? `ICT_C_EA_IDX_L : `ICT_C_EA_IDX_BW;
        EA_ABSL: next_state = long_in ? `ICT_C_EA_ABSL_L : `ICT_C_EA_ABSL_BW;
        EA_IMM: next_state = long_in ? `ICT_C_EA_IND_L : `ICT_C_EA_IND_BW;
        default: next_state = `ICT_C_EA_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign cost_out = state;
endmodule

// ===== hw/ict_bus_cycle.sv
// Four-clock bus cycle engine with wait states.
`timescale 1ns/1ps

module ict_bus_cycle (
  input wire logic clk_in, // System clock.
  input wire logic rst_n_in, // Synchronised reset, active low.
  input wire logic start_in, // Start a cycle when ready.
  input wire ict_pkg::ict_bus_kind_t kind_in, // Kind of cycle to start.
  input wire logic ack_in, // Synchronised memory acknowledge.
  output logic ready_out, // Can take a start this cycle.
  output ict_pkg::ict_bus_t bus_out // Registered bus strobes.
);
  import ict_pkg::*;

  typedef struct packed {
    logic active;
    logic [1:0] cnt;
    ict_bus_kind_t kind;
  } ict_bc_state_t;

  ict_bc_state_t state;
  ict_bc_state_t next_state;
  logic finishing;

  // ==========================================
  // Cycle counting
  // The last clock repeats as a wait state until memory acknowledges.
  assign finishing = state.active && (state.cnt == `ICT_BUS_LAST) && ack_in;
  assign ready_out = !state.active || finishing;

  always_comb begin
    next_state = state;
    if (finishing) begin
      next_state.active = 1'b0;
    end else if (state.active && (state.cnt != `ICT_BUS_LAST)) begin
      next_state.cnt = state.cnt + 2'h1;
    end
    if (start_in && ready_out) begin
      next_state.active = 1'b1;
      next_state.cnt = 2'h0;
      next_state.kind = kind_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign bus_out.active = state.active;
  assign bus_out.rd = state.active && (state.kind != BK_WRITE);
  assign bus_out.wr = state.active && (state.kind == BK_WRITE);
  assign bus_out.iack = state.active && (state.kind == BK_IACK);
endmodule

// ===== hw/ict_timing_core.sv
// Instruction cycle timing sequencer: plays out clocks, reads and writes per instruction.
// What this block does
// - Every read and write bus cycle lasts four clocks; wait states stretch it.
// - An instruction's total includes its own fetch and all operand reads and writes.
// - Marked instructions add the address computation clocks and reads.
// - Indirect and post-increment addressing: 4 clocks one read, long 8 two.
// - Pre-decrement addressing: 6 clocks one read, long 10 clocks two reads.
// - PC-relative indexed addressing: 10 clocks two reads, long 14 three.
// - Address computation never issues a write cycle.
// - Register shift or rotate: 10 (long 12) plus twice the count clocks, two reads.
// - Memory shift or rotate: word only, 16 clocks, two reads, two writes.
// - Dynamic register bit ops 10, 12 or 14 clocks; static ones 18, 20 or 22, four reads.
// - Branch taken 18 clocks four reads; not taken 12 or 20.
// - Bounds check trapping 68 clocks 8/6; passing 14 clocks, plus address.
// - Multi-register load 24+8n or 24+16n; store 16+8n or 16+16n with four reads.
// - Pointer jump 16 clocks four reads; call 32 clocks four reads four writes.
// - Load address 8 clocks two reads; push address 24 clocks 2/4.
// - Extended add/subtract registers 8 or 12 clocks; byte memory 22 clocks 4/1.
// - Bus/address error 94 clocks 8/14; trace, trap, illegal, privilege 62 clocks 8/6.
// - Interrupt takes 72 clocks 9/6 with a four-clock acknowledge cycle.
// - After reset and halt release, 64 clocks and twelve reads precede execution.
`timescale 1ns/1ps

module ict_timing_core (
  input wire logic clk_in, // 40 MHz clock.
  input wire logic rst_n_in, // Asynchronous reset, active low.
  input wire logic ext_reset_n_in, // Reset pin from outside, active low.
  input wire logic ext_halt_n_in, // Halt pin from outside, active low.
  input wire logic mem_ack_in, // Memory acknowledge pin, high ends a bus cycle.
  input wire logic req_valid_in, // Instruction request valid.
  input wire ict_pkg::ict_req_t req_in, // Instruction descriptor.
  output logic req_ready_out, // Ready to take a request.
  output logic done_out, // One-cycle pulse after an instruction's last clock.
  output logic exec_start_out, // One-cycle pulse when the reset sequence ends.
  output logic err_out, // One-cycle pulse on an unknown class.
  output ict_pkg::ict_cost_t cost_out, // Total cost of the running instruction.
  output ict_pkg::ict_bus_t bus_out // Bus strobes.
);
  import ict_pkg::*;

  typedef struct packed {
    logic rst_meta;
    logic rst_sync_n;
    logic halt_meta;
    logic halt_sync_n;
    logic ack_meta;
    logic ack_sync;
    ict_state_t st;
    logic booting;
    logic ea_add;
    logic iack_first;
    ict_cost_t cost;
    logic [`ICT_CNT_W-1:0] rd_left;
    logic [`ICT_CNT_W-1:0] wr_left;
    logic [`ICT_CLK_W-1:0] idle_left;
    logic done;
    logic exec_start;
    logic err;
  } ict_core_state_t;

  ict_core_state_t state;
  ict_core_state_t next_state;
  logic [1:0] rst_shift;
  logic rst_n;
  logic accept;
  logic bus_start;
  ict_bus_kind_t bus_kind;
  logic bus_ready;
  ict_cost_t ea_cost;
  ict_cost_t sum;
  logic [`ICT_CLK_W-1:0] bus_clks;

  // ==========================================
  // Reset release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_shift <= 2'h0;
    end else begin
      rst_shift <= {rst_shift[0], 1'b1};
    end
  end
  assign rst_n = rst_shift[1];

  // ==========================================
  // Cost of each instruction class
  function automatic ict_cost_t base_cost(input ict_req_t r);
    ict_cost_t c;
    logic [`ICT_CLK_W-1:0] n10;
    logic [`ICT_CLK_W-1:0] nm;
    logic [`ICT_CNT_W-1:0] nr;
    c = '0;
    n10 = {4'h0, r.count};
    nm = {5'h00, r.count[4:0]};
    nr = {2'h0, r.count[4:0]};
    case (r.cls)
      CL_SHIFT_REG: begin
        c.clks = ((r.size == SZ_LONG) ? `ICT_SHIFT_L_BASE : `ICT_SHIFT_BW_BASE) + (n10 << 1);
        c.reads = `ICT_SHIFT_RD;
      end
      CL_SHIFT_MEM: c = `ICT_C_SHIFT_MEM;
      CL_BIT_REG: begin
        case (r.bitop)
          BIT_CLEAR: c = r.static_num ? `ICT_C_BIT_STA_CLR : `ICT_C_BIT_DYN_CLR;
          BIT_TEST: c = r.static_num ? `ICT_C_BIT_STA_TST : `ICT_C_BIT_DYN_TST;
          default: c = r.static_num ? `ICT_C_BIT_STA : `ICT_C_BIT_DYN;
        endcase
      end
      CL_BRANCH: begin
        if (r.taken) begin
          c = `ICT_C_BR_TAKEN;
        end else begin
          c = r.disp_word ? `ICT_C_BR_NT_WORD : `ICT_C_BR_NT_BYTE;
        end
      end
      CL_CHK: c = r.taken ? `ICT_C_CHK_TRAP : `ICT_C_CHK_PASS;
      CL_MULTI_REGISTER_MOVE_OP_LD: begin
        c.clks = `ICT_MULTI_REGISTER_MOVE_OP_LD_CLK + ((r.size == SZ_LONG) ? (nm << 4) : (nm << 3));
        c.reads = `ICT_MULTI_REGISTER_MOVE_OP_LD_RD + ((r.size == SZ_LONG) ? (nr << 2) : (nr << 1));
      end
      CL_MULTI_REGISTER_MOVE_OP_ST: begin
        c.clks = `ICT_MULTI_REGISTER_MOVE_OP_ST_CLK + ((r.size == SZ_LONG) ? (nm << 4) : (nm << 3));
        c.reads = `ICT_MULTI_REGISTER_MOVE_OP_ST_RD;
        c.writes = (r.size == SZ_LONG) ? (nr << 2) : (nr << 1);
      end
      CL_JUMP: c = `ICT_C_JUMP;
      CL_CALL: c = `ICT_C_CALL;
      CL_LOAD_ADDR: c = `ICT_C_LOAD_ADDR;
      CL_PUSH_ADDR: c = `ICT_C_PUSH_ADDR;
      CL_XADD_REG: c = (r.size == SZ_LONG) ? `ICT_C_XADD_REG_L : `ICT_C_XADD_REG_BW;
      CL_XADD_MEM: begin
        case (r.size)
          SZ_BYTE: c = `ICT_C_XADD_MEM_B;
          SZ_WORD: c = `ICT_C_XADD_MEM_W;
          default: c = `ICT_C_XADD_MEM_L;
        endcase
      end
      CL_EXC_BUS: c = `ICT_C_EXC_BUS;
      CL_EXC_TRAP: c = `ICT_C_EXC_TRAP;
      CL_EXC_INT: c = `ICT_C_EXC_INT;
      default: c = '0;
    endcase
    return c;
  endfunction

  // ==========================================
  // Address cost lookup
  // Both classes that add an address cost work on word operands.
  assign accept = (state.st == ST_READY) && req_valid_in && state.rst_sync_n;

  ict_ea_cost u_ea_cost (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .load_in(accept),
    .mode_in(req_in.ea_mode),
    .long_in(1'b0),
    .cost_out(ea_cost)
  );

  // ==========================================
  // Bus cycle engine
  ict_bus_cycle u_bus_cycle (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .start_in(bus_start),
    .kind_in(bus_kind),
    .ack_in(state.ack_sync),
    .ready_out(bus_ready),
    .bus_out(bus_out)
  );

  // ==========================================
  // Totals
  always_comb begin
    sum = state.cost;
    if (state.ea_add) begin
      sum.clks = state.cost.clks + ea_cost.clks;
      sum.reads = state.cost.reads + ea_cost.reads;
    end
    bus_clks = (`ICT_CLK_W'(sum.reads) + `ICT_CLK_W'(sum.writes)) << 2;
  end

  // ==========================================
  // Sequencer
  always_comb begin
    next_state = state;
    next_state.rst_meta = ext_reset_n_in;
    next_state.rst_sync_n = state.rst_meta;
    next_state.halt_meta = ext_halt_n_in;
    next_state.halt_sync_n = state.halt_meta;
    next_state.ack_meta = mem_ack_in;
    next_state.ack_sync = state.ack_meta;
    next_state.done = 1'b0;
    next_state.exec_start = 1'b0;
    next_state.err = 1'b0;
    bus_start = 1'b0;
    bus_kind = BK_READ;
    case (state.st)
      ST_BOOT: begin
        if (state.rst_sync_n && state.halt_sync_n && bus_ready) begin
          next_state.cost = `ICT_C_RESET;
          next_state.booting = 1'b1;
          next_state.ea_add = 1'b0;
          next_state.iack_first = 1'b0;
          next_state.st = ST_LOAD;
        end
      end
      ST_READY: begin
        if (accept) begin
          if (req_in.cls > CL_EXC_INT) begin
            next_state.err = 1'b1;
          end else begin
            next_state.cost = base_cost(req_in);
            next_state.ea_add = (req_in.cls == CL_SHIFT_MEM) || (req_in.cls == CL_CHK);
            next_state.iack_first = (req_in.cls == CL_EXC_INT);
            next_state.booting = 1'b0;
            next_state.st = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        next_state.cost = sum;
        next_state.rd_left = sum.reads;
        next_state.wr_left = sum.writes;
        next_state.idle_left = sum.clks - bus_clks;
        next_state.st = ST_READ;
      end
      ST_READ: begin
        if (bus_ready) begin
          if (state.rd_left != '0) begin
            bus_start = 1'b1;
            bus_kind = state.iack_first ? BK_IACK : BK_READ;
            next_state.iack_first = 1'b0;
            next_state.rd_left = state.rd_left - 7'h01;
          end else if (state.idle_left != '0) begin
            next_state.st = ST_IDLE;
          end else if (state.wr_left != '0) begin
            bus_start = 1'b1;
            bus_kind = BK_WRITE;
            next_state.wr_left = state.wr_left - 7'h01;
            next_state.st = ST_WRITE;
          end else begin
            next_state.done = !state.booting;
            next_state.exec_start = state.booting;
            next_state.st = ST_READY;
          end
        end
      end
      ST_IDLE: begin
        next_state.idle_left = state.idle_left - 10'h001;
        if (state.idle_left == 10'h001) begin
          if (state.wr_left != '0) begin
            bus_start = 1'b1;
            bus_kind = BK_WRITE;
            next_state.wr_left = state.wr_left - 7'h01;
            next_state.st = ST_WRITE;
          end else begin
            next_state.done = !state.booting;
            next_state.exec_start = state.booting;
            next_state.st = ST_READY;
          end
        end
      end
      ST_WRITE: begin
        if (bus_ready) begin
          if (state.wr_left != '0) begin
            bus_start = 1'b1;
            bus_kind = BK_WRITE;
            next_state.wr_left = state.wr_left - 7'h01;
          end else begin
            next_state.done = !state.booting;
            next_state.exec_start = state.booting;
            next_state.st = ST_READY;
          end
        end
      end
      default: next_state.st = ST_BOOT;
    endcase
    // A fresh reset from outside abandons the instruction and restarts the reset sequence.
    if (!state.rst_sync_n) begin
      next_state.st = ST_BOOT;
      next_state.done = 1'b0;
      next_state.exec_start = 1'b0;
      bus_start = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign req_ready_out = (state.st == ST_READY) && state.rst_sync_n;
  assign done_out = state.done;
  assign exec_start_out = state.exec_start;
  assign err_out = state.err;
  assign cost_out = state.cost;
endmodule

// ===== verification/ict_mem_model.sv
// Behavioural memory that acknowledges bus cycles, promptly or with wait states.
`timescale 1ns/1ps

module ict_mem_model (
  input wire logic clk_in, // Clock.
  input wire logic rst_n_in, // Reset, active low.
  input wire logic slow_in, // Insert wait states at random.
  input wire ict_pkg::ict_bus_t bus_in, // Bus strobes from the core.
  output logic ack_out // Acknowledge to the core.
);
  import ict_pkg::*;

  logic [7:0] lfsr;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lfsr <= 8'hA5;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  // Idle, the line shows a changing pattern.
  assign ack_out = bus_in.active ? !(slow_in && lfsr[1]) : lfsr[0];
endmodule

// ===== verification/ict_timing_core_sva.sv
// Concurrent checks on the ports of the instruction timing sequencer.
`timescale 1ns/1ps

module ict_timing_core_sva (
  input wire logic clk_in, // Clock.
  input wire logic rst_n_in, // Reset, active low.
  input wire logic ext_reset_n_in, // Outside reset pin.
  input wire logic ext_halt_n_in, // Outside halt pin.
  input wire logic mem_ack_in, // Memory acknowledge.
  input wire logic req_valid_in, // Request valid.
  input wire ict_pkg::ict_req_t req_in, // Request descriptor.
  input wire logic req_ready_out, // Ready for a request.
  input wire logic done_out, // Done pulse.
  input wire logic exec_start_out, // Execution start pulse.
  input wire logic err_out, // Error pulse.
  input wire ict_pkg::ict_cost_t cost_out, // Running cost.
  input wire ict_pkg::ict_bus_t bus_out // Bus strobes.
);
  import ict_pkg::*;

  wire take = req_valid_in && req_ready_out;
  logic [6:0] rd_clks;

  // Read clocks since the outside reset was last low or the last execution start pulse.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_clks <= 7'h00;
    end else if (!ext_reset_n_in || exec_start_out) begin
      rd_clks <= 7'h00;
    end else if (bus_out.rd && rd_clks != 7'h7F) begin
      rd_clks <= rd_clks + 7'h01;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_bus_len;
    $rose(bus_out.active) |-> bus_out.active [*4];
  endproperty
  a_bus_len: assert property (p_bus_len) else $error("short bus cycle");

  property p_idle;
    !bus_out.active |-> !(bus_out.rd || bus_out.wr || bus_out.iack);
  endproperty
  a_idle: assert property (p_idle) else $error("stray strobe");

  property p_shift;
    take && req_in.cls == CL_SHIFT_REG && req_in.size != SZ_LONG |->
      ##3 cost_out == {10'h00A + {3'h0, $past(req_in.count, 3), 1'b0}, 7'h02, 7'h00};
  endproperty
  a_shift: assert property (p_shift) else $error("shift cost wrong");

  property p_branch;
    take && req_in.cls == CL_BRANCH && req_in.taken |-> ##3 cost_out == {10'h012, 7'h04, 7'h00};
  endproperty
  a_branch: assert property (p_branch) else $error("branch cost wrong");

  property p_jump;
    take && req_in.cls == CL_JUMP |-> ##3 cost_out == {10'h010, 7'h04, 7'h00};
  endproperty
  a_jump: assert property (p_jump) else $error("jump cost wrong");

  property p_exc;
    take && req_in.cls == CL_EXC_BUS |-> ##3 cost_out == {10'h05E, 7'h08, 7'h0E};
  endproperty
  a_exc: assert property (p_exc) else $error("bus error cost wrong");

  property p_int;
    take && req_in.cls == CL_EXC_INT |-> ##3 (cost_out == {10'h048, 7'h09, 7'h06}) ##[0:1] (bus_out.iack && bus_out.rd);
  endproperty
  a_int: assert property (p_int) else $error("interrupt wrong");

  property p_reset;
    exec_start_out |-> rd_clks == 7'h30;
  endproperty
  a_reset: assert property (p_reset) else $error("reset reads wrong");

  property p_chk;
    take && req_in.cls == CL_CHK && !req_in.taken && req_in.ea_mode == EA_IND |->
      ##3 cost_out == {10'h012, 7'h03, 7'h00};
  endproperty
  a_chk: assert property (p_chk) else $error("bounds check cost wrong");

  property p_nowrite;
    take && req_in.cls == CL_CHK && !req_in.taken |-> ##3 cost_out.writes == 7'h00;
  endproperty
  a_nowrite: assert property (p_nowrite) else $error("address writes");

  c_multi_register_move_op: cover property (take && req_in.cls == CL_MULTI_REGISTER_MOVE_OP_LD);
  c_boot: cover property (exec_start_out);
  c_wait: cover property (bus_out.active && !mem_ack_in);
endmodule

bind ict_timing_core ict_timing_core_sva i_sva (.*);

// ===== verification/testbench.sv
// Self-checking bench for the instruction timing sequencer.
`timescale 1ns/1ps
`include "ict_defines.svh"

module testbench;
  import ict_pkg::*;

  logic clk_in = 1'b0;
  logic rst_n_in, ext_reset_n_in, ext_halt_n_in, req_valid_in, slow, mem_ack_in;
  logic req_ready_out, done_out, exec_start_out, err_out;
  ict_req_t req_in;
  ict_cost_t cost_out;
  ict_bus_t bus_out;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 32'h1491;

  always #12.5 clk_in = ~clk_in;

  ict_timing_core i_dut (.clk_in, .rst_n_in, .ext_reset_n_in, .ext_halt_n_in, .mem_ack_in, .req_valid_in,
    .req_in, .req_ready_out, .done_out, .exec_start_out, .err_out, .cost_out, .bus_out);
  ict_mem_model i_mem (.clk_in, .rst_n_in, .slow_in(slow), .bus_in(bus_out), .ack_out(mem_ack_in));

  // ==========================================
  // Reporting
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ==========================================
  // Expected costs
  function automatic ict_cost_t ea_cost(input ict_ea_mode_t m);
    case (m)
      EA_IND, EA_POSTINC: return `ICT_C_EA_IND_BW;
      EA_PREDEC: return `ICT_C_EA_PRE_BW;
      EA_DISP, EA_ABSW, EA_PCDISP: return `ICT_C_EA_DISP_BW;
      EA_INDEX, EA_PCINDEX: return `ICT_C_EA_IDX_BW;
      EA_ABSL: return `ICT_C_EA_ABSL_BW;
      default: return '0;
    endcase
  endfunction

  function automatic ict_cost_t exp_cost(input ict_req_t r);
    logic [9:0] n;
    logic lng;
    int s;
    ict_cost_t c;
    ict_cost_t e;
    n = {5'h00, r.count[4:0]};
    lng = (r.size == SZ_LONG);
    s = lng ? 2 : 1;
    case (r.cls)
      CL_SHIFT_REG: c = {(lng ? 10'h00C : 10'h00A) + {3'h0, r.count, 1'b0}, 7'h02, 7'h00};
      CL_SHIFT_MEM: c = `ICT_C_SHIFT_MEM;
      CL_BIT_REG: c = {(r.bitop == BIT_CLEAR ? 10'h00E : r.bitop == BIT_TEST ? 10'h00A : 10'h00C)
        + (r.static_num ? 10'h008 : 10'h000), r.static_num ? 7'h04 : 7'h02, 7'h00};
      CL_BRANCH: c = r.taken ? `ICT_C_BR_TAKEN : r.disp_word ? `ICT_C_BR_NT_WORD : `ICT_C_BR_NT_BYTE;
      CL_CHK: c = r.taken ? `ICT_C_CHK_TRAP : `ICT_C_CHK_PASS;
      CL_MULTI_REGISTER_MOVE_OP_LD: c = {10'h018 + (n << (s + 2)), 7'h06 + 7'(n << s), 7'h00};
      CL_MULTI_REGISTER_MOVE_OP_ST: c = {10'h010 + (n << (s + 2)), 7'h04, 7'(n << s)};
      CL_JUMP: c = `ICT_C_JUMP;
      CL_CALL: c = `ICT_C_CALL;
      CL_LOAD_ADDR: c = `ICT_C_LOAD_ADDR;
      CL_PUSH_ADDR: c = `ICT_C_PUSH_ADDR;
      CL_XADD_REG: c = lng ? `ICT_C_XADD_REG_L : `ICT_C_XADD_REG_BW;
      CL_XADD_MEM: c = lng ? `ICT_C_XADD_MEM_L : r.size == SZ_WORD ? `ICT_C_XADD_MEM_W : `ICT_C_XADD_MEM_B;
      CL_EXC_BUS: c = `ICT_C_EXC_BUS;
      CL_EXC_TRAP: c = `ICT_C_EXC_TRAP;
      CL_EXC_INT: c = `ICT_C_EXC_INT;
      default: c = '0;
    endcase
    if (r.cls == CL_SHIFT_MEM || r.cls == CL_CHK) begin
      e = ea_cost(r.ea_mode);
      c.clks = c.clks + e.clks;
      c.reads = c.reads + e.reads;
    end
    return c;
  endfunction

  // Memory shifts are word only; register lists fit the read counter.
  function automatic ict_req_t fix(input ict_req_t r);
    r.size = (r.cls == CL_SHIFT_MEM) ? SZ_WORD : r.size;
    r.count = (r.cls inside {CL_MULTI_REGISTER_MOVE_OP_LD, CL_MULTI_REGISTER_MOVE_OP_ST} && &r.count[4:0]) ? 6'h1E : r.count;
    return r;
  endfunction

  // ==========================================
  // Transfers
  task automatic measure(output int k, output int k0, output int rdc, output int wrc);
    {k, k0, rdc, wrc} = '0;
    do begin
      @(posedge clk_in);
      k++;
      k0 = (k0 == 0 && bus_out.active === 1'b1) ? k : k0;
      rdc += int'(bus_out.rd);
      wrc += int'(bus_out.wr);
    end while (done_out !== 1'b1 && exec_start_out !== 1'b1);
  endtask

  task automatic run(input ict_req_t r, input logic s);
    ict_cost_t e;
    int k, k0, rdc, wrc;
    e = exp_cost(r);
    slow <= s;
    req_in <= r;
    req_valid_in <= 1'b1;
    do @(posedge clk_in); while (req_ready_out !== 1'b1);
    req_valid_in <= 1'b0;
    if (r.cls[4]) begin
      k = 0;
      repeat (3) begin
        @(posedge clk_in);
        k += int'(err_out);
      end
      check(k, 1);
      return;
    end
    measure(k, k0, rdc, wrc);
    check(cost_out, e);
    if (!s) begin
      check(k - k0, e.clks);
      check(rdc, 4 * e.reads);
      check(wrc, 4 * e.writes);
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    ict_req_t r;
    int i, k, k0, rdc, wrc;
    {rst_n_in, ext_reset_n_in, ext_halt_n_in, req_valid_in, slow} = '0;
    req_in = '0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    ext_reset_n_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    check(bus_out, 4'h0);
    ext_halt_n_in <= 1'b1;
    repeat (30) @(posedge clk_in);
    ext_reset_n_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    ext_reset_n_in <= 1'b1;
    measure(k, k0, rdc, wrc);
    check(k - k0, 64);
    check(rdc, 48);
    check(wrc, 0);
    r = '0;
    r.cls = CL_CHK;
    r.ea_mode = EA_IND;
    run(r, 1'b0);
    r.cls = ict_class_t'(5'h1F);
    run(r, 1'b0);
    for (i = 0; i < 64; i++) begin
      r.cls = ict_class_t'(i[3:0]);
      r.size = ict_size_t'(2'(i % 3));
      r.bitop = ict_bitop_t'(i[5:4]);
      r.ea_mode = ict_ea_mode_t'(4'(i % 11));
      r.count = i[4] ? 6'h3F : 6'h00;
      r.taken = i[4];
      r.disp_word = i[5];
      r.static_num = i[5] ^ i[4];
      run(fix(r), 1'b0);
    end
    for (i = 0; i < 200; i++) begin
      r.cls = ict_class_t'(5'($unsigned($random(seed)) % 17));
      r.size = ict_size_t'(2'($unsigned($random(seed)) % 3));
      r.bitop = ict_bitop_t'(2'($random(seed)));
      r.ea_mode = ict_ea_mode_t'(4'($unsigned($random(seed)) % 11));
      {r.count, r.taken, r.disp_word, r.static_num} = 9'($random(seed));
      run(fix(r), 1'($random(seed)));
    end
    finish_test();
  end
endmodule
